/* verilog/msg_map.svh */
`ifndef MSG_MAP_SVH
`define MSG_MAP_SVH

// ==========================================================================
// Host command codes.
`define MSG_RUN_CMD        8'h28
`define MSG_SP_RD_CMD      8'h0C

// ==========================================================================
// Key store figures.
`define MSG_KEY_LAST       4'h7
`define MSG_KEY_IDX_W      3
`define MSG_ERASED_BYTE    8'hFF

// ==========================================================================
// Status byte in internal RAM and the value shown for a locked read.
`define MSG_STAT_ADDR      16'h0080
`define MSG_STAT_UNLOCKED  8'h40
`define MSG_STAT_LOCKED    8'h00
`define MSG_INVALID_DATA   8'h00

// ==========================================================================
// Stack frame layout: six bytes, offsets counted from the final pointer.
`define MSG_FRAME_LAST     4'h5
`define MSG_PULL_DONE      4'h6
`define MSG_FRAME_SIZE     16'h0006
`define MSG_SP_STEP        16'h0001
`define MSG_PCH_OFS        16'h0005
`define MSG_PCL_OFS        16'h0006

`endif

/* verilog/msg_pkg.sv */
`default_nettype none

// ==========================================================================
// Types shared by the monitor security gate.
package msg_pkg;

    // Control sequencer states.
    typedef enum logic [2:0] {
        MSG_ST_STACK = 3'b000,
        MSG_ST_KEY   = 3'b001,
        MSG_ST_CMP   = 3'b010,
        MSG_ST_FLAG  = 3'b011,
        MSG_ST_BREAK = 3'b100,
        MSG_ST_IDLE  = 3'b101,
        MSG_ST_PULL  = 3'b110,
        MSG_ST_RUN   = 3'b111
    } msg_state_e;

    // Instruction marks shown while the stack engine works.
    typedef enum logic [1:0] {
        MSG_INSTR_SOFT_INT = 2'b00,
        MSG_INSTR_PUSH_HI  = 2'b01,
        MSG_INSTR_PULL_HI  = 2'b10,
        MSG_INSTR_RET_INT  = 2'b11
    } msg_instr_e;

    typedef logic [7:0] msg_byte_t;

endpackage

`default_nettype wire

/* verilog/msg_key_if.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Link between the sequencer and the key store.
interface msg_key_if;
    import msg_pkg::*;

    logic [2:0] rd_idx;
    msg_byte_t  rd_data;
    logic       wr_en;
    logic [2:0] wr_idx;
    msg_byte_t  wr_data;
    logic       erase;

    modport ctrl (output rd_idx, wr_en, wr_idx, wr_data, erase, input rd_data);
    modport mem  (input rd_idx, wr_en, wr_idx, wr_data, erase, output rd_data);
endinterface

`default_nettype wire

/* verilog/msg_key_mem.sv */
`timescale 1ns/100ps
`default_nettype none
`include "msg_map.svh"

// ==========================================================================
// Eight stored key bytes with a registered read port.
module msg_key_mem
    import msg_pkg::*;
(
    // Clock and power-on reset.
    input  wire logic clk,
    input  wire logic rst_b,
    // Key store port.
    msg_key_if.mem    key
);

    msg_byte_t mem_reg [8];
    msg_byte_t rd_reg;

    // Each key byte takes a write, or the erased value on a mass erase.
    generate
        for (genvar i = 0; i < 8; i++) begin : g_key
            always_ff @(posedge clk) begin
                if (!rst_b || key.erase) begin
                    mem_reg[i] <= `MSG_ERASED_BYTE;
                end else if (key.wr_en && key.wr_idx == 3'(i)) begin
                    mem_reg[i] <= key.wr_data;
                end
            end
        end
    endgenerate

    // Read data leave through a register.
    always_ff @(posedge clk) begin
        rd_reg <= mem_reg[key.rd_idx];
    end

    assign key.rd_data = rd_reg;

    // ======================================================================
    // Checks.
    // Erase gives blanks.
    erase_blank_a : assert property (@(posedge clk) disable iff (!rst_b)
        key.erase ##1 !key.wr_en |=> key.rd_data == `MSG_ERASED_BYTE)
        else $error("Key byte not blank after mass erase.");

    erase_seen_c : cover property (@(posedge clk) disable iff (!rst_b) key.erase);

endmodule // msg_key_mem

`default_nettype wire

/* verilog/msg_gate.sv */
`timescale 1ns/100ps
`default_nettype none
`include "msg_map.svh"

// How it works
// - Run command pulls index high, then returns.
// - Entry stacks interrupt frame, then index high.
// - Stack pointer read answers pointer plus one.
// - Program counter bytes at pointer plus five, six.
// - After power-on, wait for eight key bytes.
// - Full match unlocks memory reads and fetches.
// - Unlock persists until the next power-on reset.
// - Mismatch: invalid reads, fetch raises illegal reset.
// - Break sent only after all eight bytes, except on warm-reset entry, which skips the key.
// - Status byte bit six shows unlocked state.
// - Mass erase leaves key bytes all ones.

module msg_gate
    import msg_pkg::*;
(
    // Clock and power-on reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Any other reset source, one-cycle pulse.
    input  wire logic        warm_reset,
    // Bytes from the host serial receiver.
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    // Answers toward the host serial transmitter.
    output logic             tx_break,
    output logic             sp_reply_valid,
    output logic [15:0]      sp_reply,
    // Processor state at monitor entry.
    input  wire logic [15:0] cpu_pc,
    input  wire logic [15:0] cpu_sp,
    input  wire logic [7:0]  cpu_a,
    input  wire logic [7:0]  cpu_x,
    input  wire logic [7:0]  cpu_h,
    input  wire logic [7:0]  cpu_ccr,
    // Internal RAM port, read data one cycle after the read strobe.
    output logic             ram_wr_en,
    output logic             ram_rd_en,
    output logic [15:0]      ram_addr,
    output logic [7:0]       ram_wr_data,
    input  wire logic [7:0]  ram_rd_data,
    // Instruction marks of the stack engine.
    output logic             instr_valid,
    output msg_instr_e       instr_code,
    // Processor state handed back on run.
    output logic             resume_valid,
    output logic [15:0]      resume_pc,
    output logic [15:0]      resume_sp,
    output logic [7:0]       resume_a,
    output logic [7:0]       resume_x,
    output logic [7:0]       resume_h,
    output logic [7:0]       resume_ccr,
    // Nonvolatile memory read path and fetch check.
    input  wire logic        nvm_rd_en,
    input  wire logic [7:0]  nvm_rd_data,
    output logic             gated_rd_valid,
    output logic [7:0]       gated_rd_data,
    input  wire logic        fetch_en,
    output logic             illegal_addr_reset,
    // Key store maintenance.
    input  wire logic        key_wr_en,
    input  wire logic [2:0]  key_wr_idx,
    input  wire logic [7:0]  key_wr_data,
    input  wire logic        mass_erase,
    // Lock state.
    output logic             unlocked
);

    // ======================================================================
    // State.
    msg_state_e   state_reg;
    msg_state_e   state_next;
    logic [3:0]   cnt_reg;
    logic [3:0]   cnt_next;
    logic         mismatch_reg;
    logic         skip_key_reg;
    logic         unlock_reg;
    logic         key_last_seen_reg;
    msg_byte_t    rx_hold_reg;
    logic [15:0]  sp_reg;
    msg_byte_t    pull_reg [6];
    logic         sp_reply_valid_reg;
    logic [15:0]  sp_reply_reg;
    logic         resume_valid_reg;
    logic         gated_rd_valid_reg;
    msg_byte_t    gated_rd_data_reg;
    logic         illegal_reset_reg;

    msg_key_if key_bus ();

    msg_key_mem u_key_mem (
        .clk   (clk),
        .rst_b (rst_b),
        .key   (key_bus.mem)
    );

    // Frame byte for a given offset above the final pointer.
    function automatic msg_byte_t frame_byte(input logic [3:0] ofs);
        unique case (ofs)
            4'h1:    frame_byte = cpu_h;
            4'h2:    frame_byte = cpu_ccr;
            4'h3:    frame_byte = cpu_a;
            4'h4:    frame_byte = cpu_x;
            4'h5:    frame_byte = cpu_pc[15:8];
            default: frame_byte = cpu_pc[7:0];
        endcase
    endfunction

    // ======================================================================
    // Decoding.
    wire in_stack   = (state_reg == MSG_ST_STACK);
    wire in_key     = (state_reg == MSG_ST_KEY);
    wire in_cmp     = (state_reg == MSG_ST_CMP);
    wire in_flag    = (state_reg == MSG_ST_FLAG);
    wire in_idle    = (state_reg == MSG_ST_IDLE);
    wire in_pull    = (state_reg == MSG_ST_PULL);
    wire run_cmd    = in_idle && rx_valid && (rx_data == `MSG_RUN_CMD);
    wire sp_rd_cmd  = in_idle && rx_valid && (rx_data == `MSG_SP_RD_CMD);
    wire byte_ok    = (rx_hold_reg == key_bus.rd_data);
    wire key_last   = in_cmp && (cnt_reg == `MSG_KEY_LAST);
    wire full_match = key_last && !mismatch_reg && byte_ok;
    wire stack_last = in_stack && (cnt_reg == `MSG_FRAME_LAST);
    wire pull_done  = in_pull && (cnt_reg == `MSG_PULL_DONE);
    wire [15:0] cnt_wide   = {12'h000, cnt_reg};
    // Push goes downward from the entry pointer, ending with index high.
    wire [15:0] push_addr  = cpu_sp - cnt_wide;
    // Pull walks upward from one above the saved pointer.
    wire [15:0] pull_addr  = sp_reg + `MSG_SP_STEP + cnt_wide;
    wire [3:0]  push_ofs   = `MSG_PULL_DONE - cnt_reg;

    // Key store hookup: compare index follows the byte counter.
    assign key_bus.rd_idx  = cnt_reg[2:0];
    assign key_bus.wr_en   = key_wr_en;
    assign key_bus.wr_idx  = key_wr_idx;
    assign key_bus.wr_data = key_wr_data;
    assign key_bus.erase   = mass_erase;

    assign ram_wr_en   = (in_stack || in_flag) && rst_b;
    assign ram_rd_en   = in_pull && (cnt_reg != `MSG_PULL_DONE);
    assign ram_addr    = in_flag ? `MSG_STAT_ADDR : (in_pull ? pull_addr : push_addr);
    assign ram_wr_data = in_flag ? (unlock_reg ? `MSG_STAT_UNLOCKED : `MSG_STAT_LOCKED)
                                 : frame_byte(push_ofs);

    // Instruction marks: two on entry, two on run.
    assign instr_valid = rst_b && ((in_stack && (cnt_reg == 4'h0 || stack_last)) || run_cmd ||
                         (in_pull && cnt_reg == 4'h1));
    assign instr_code  = in_stack ? (stack_last ? MSG_INSTR_PUSH_HI : MSG_INSTR_SOFT_INT)
                                  : (run_cmd ? MSG_INSTR_PULL_HI : MSG_INSTR_RET_INT);

    assign tx_break       = (state_reg == MSG_ST_BREAK);
    assign sp_reply_valid = sp_reply_valid_reg;
    assign sp_reply       = sp_reply_reg;
    assign resume_valid   = resume_valid_reg;
    assign resume_sp      = sp_reg;
    assign resume_h       = pull_reg[0];
    assign resume_ccr     = pull_reg[1];
    assign resume_a       = pull_reg[2];
    assign resume_x       = pull_reg[3];
    assign resume_pc      = {pull_reg[4], pull_reg[5]};
    assign gated_rd_valid = gated_rd_valid_reg;
    assign gated_rd_data  = gated_rd_data_reg;
    assign illegal_addr_reset = illegal_reset_reg;
    assign unlocked       = unlock_reg;

    // ======================================================================
    // Next state of the sequencer.
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            MSG_ST_STACK: begin
                cnt_next = cnt_reg + 4'h1;
                if (stack_last) begin
                    state_next = skip_key_reg ? MSG_ST_FLAG : MSG_ST_KEY;
                    cnt_next   = 4'h0;
                end
            end
            MSG_ST_KEY: begin
                if (rx_valid) begin
                    state_next = MSG_ST_CMP;
                end
            end
            MSG_ST_CMP: begin
                cnt_next   = cnt_reg + 4'h1;
                state_next = MSG_ST_KEY;
                if (key_last) begin
                    state_next = MSG_ST_FLAG;
                    cnt_next   = 4'h0;
                end
            end
            MSG_ST_FLAG:  state_next = MSG_ST_BREAK;
            MSG_ST_BREAK: state_next = MSG_ST_IDLE;
            MSG_ST_IDLE: begin
                if (run_cmd) begin
                    state_next = MSG_ST_PULL;
                    cnt_next   = 4'h0;
                end
            end
            MSG_ST_PULL: begin
                cnt_next = cnt_reg + 4'h1;
                if (pull_done) begin
                    state_next = MSG_ST_RUN;
                    cnt_next   = 4'h0;
                end
            end
            MSG_ST_RUN:   state_next = MSG_ST_RUN;
        endcase
        if (warm_reset) begin
            state_next = MSG_ST_STACK;
            cnt_next   = 4'h0;
        end
    end

    // Sequencer registers; a warm reset restarts entry without the key step.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg    <= MSG_ST_STACK;
            cnt_reg      <= 4'h0;
            skip_key_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            skip_key_reg <= skip_key_reg || warm_reset;
        end
    end

    // Holds each key byte and tracks any mismatch.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_hold_reg  <= 8'h00;
            mismatch_reg <= 1'b0;
        end else begin
            if (in_key && rx_valid) begin
                rx_hold_reg <= rx_data;
            end
            if (in_cmp && !byte_ok) begin
                mismatch_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            unlock_reg        <= 1'b0;
            key_last_seen_reg <= 1'b0;
        end else begin
            unlock_reg        <= unlock_reg || full_match;
            key_last_seen_reg <= key_last;
        end
    end

    // Saved pointer: set after entry, moved past the frame on run.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sp_reg <= 16'h0000;
        end else if (stack_last) begin
            sp_reg <= cpu_sp - `MSG_FRAME_SIZE;
        end else if (pull_done) begin
            sp_reg <= sp_reg + `MSG_FRAME_SIZE;
        end
    end

    generate
        for (genvar i = 0; i < 6; i++) begin : g_pull
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    pull_reg[i] <= 8'h00;
                end else if (in_pull && cnt_reg == 4'(i + 1)) begin
                    pull_reg[i] <= ram_rd_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sp_reply_valid_reg <= 1'b0;
            sp_reply_reg       <= 16'h0000;
            resume_valid_reg   <= 1'b0;
        end else begin
            sp_reply_valid_reg <= sp_rd_cmd;
            if (sp_rd_cmd) begin
                sp_reply_reg <= sp_reg + `MSG_SP_STEP;
            end
            resume_valid_reg <= pull_done;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gated_rd_valid_reg <= 1'b0;
            gated_rd_data_reg  <= 8'h00;
            illegal_reset_reg  <= 1'b0;
        end else begin
            gated_rd_valid_reg <= nvm_rd_en;
            gated_rd_data_reg  <= unlock_reg ? nvm_rd_data : `MSG_INVALID_DATA;
            illegal_reset_reg  <= fetch_en && !unlock_reg;
        end
    end

    // ======================================================================
    // Checks.
    unlock_hold_a : assert property (@(posedge clk) disable iff (!rst_b)
        unlock_reg |=> unlock_reg)
        else $error("Unlock lost without power-on reset.");

    unlock_set_a : assert property (@(posedge clk) disable iff (!rst_b)
        full_match |=> unlock_reg && ram_wr_en && ram_addr == `MSG_STAT_ADDR
            && ram_wr_data == `MSG_STAT_UNLOCKED)
        else $error("Full key match did not unlock.");

    locked_read_a : assert property (@(posedge clk) disable iff (!rst_b)
        nvm_rd_en && !unlock_reg |=> gated_rd_valid && gated_rd_data == `MSG_INVALID_DATA)
        else $error("Locked read leaked data.");

    open_read_a : assert property (@(posedge clk) disable iff (!rst_b)
        nvm_rd_en && unlock_reg |=> gated_rd_data == $past(nvm_rd_data))
        else $error("Unlocked read did not pass data.");

    illegal_fetch_a : assert property (@(posedge clk) disable iff (!rst_b)
        fetch_en && !unlock_reg |=> illegal_addr_reset)
        else $error("Locked fetch gave no illegal reset.");

    break_after_key_a : assert property (@(posedge clk) disable iff (!rst_b)
        tx_break && !skip_key_reg |-> $past(key_last_seen_reg))
        else $error("Break sent before eight key bytes.");

    key_wait_a : assert property (@(posedge clk) disable iff (!rst_b)
        in_key && !rx_valid && !warm_reset |=> in_key && !tx_break)
        else $error("Key wait left without a byte.");

    stack_order_a : assert property (@(posedge clk) disable iff (!rst_b)
        instr_valid && instr_code == MSG_INSTR_SOFT_INT && !warm_reset
        |-> ##5 instr_valid && instr_code == MSG_INSTR_PUSH_HI)
        else $error("Index high push not five cycles after interrupt stacking.");

    pc_place_a : assert property (@(posedge clk) disable iff (!rst_b)
        in_stack && cnt_reg == 4'h1
        |-> ram_addr == cpu_sp - `MSG_PCH_OFS + `MSG_PCL_OFS - 16'h0002
            && ram_wr_data == cpu_pc[15:8])
        else $error("Program counter high byte misplaced.");

    run_pull_a : assert property (@(posedge clk) disable iff (!rst_b)
        run_cmd && !warm_reset |=> ram_rd_en && ram_addr == $past(sp_reg) + `MSG_SP_STEP
            ##7 resume_valid && resume_h == $past(ram_rd_data, 6))
        else $error("Run did not pull index high then return.");

    sp_read_a : assert property (@(posedge clk) disable iff (!rst_b)
        sp_rd_cmd |=> sp_reply_valid && sp_reply == $past(sp_reg) + `MSG_SP_STEP)
        else $error("Stack pointer read not incremented by one.");

    unlock_seen_c  : cover property (@(posedge clk) disable iff (!rst_b) full_match);
    fail_seen_c    : cover property (@(posedge clk) disable iff (!rst_b)
        key_last && !(byte_ok && !mismatch_reg));
    resume_seen_c  : cover property (@(posedge clk) disable iff (!rst_b) resume_valid);
    sp_read_seen_c : cover property (@(posedge clk) disable iff (!rst_b) sp_reply_valid);

endmodule // msg_gate

`default_nettype wire

/* tb/msg_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Development host: hands bytes to the gate's serial receiver.
module msg_host_model (
    // Clock.
    input  wire logic  clk,
    // Byte toward the gate.
    output logic       rx_valid,
    output logic [7:0] rx_data
);
    // Idle line at time zero.
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end

    // host byte delivery
    // Bytes stand at least two cycles apart, plus the gap, and the data shows the inverse once the
    // byte has gone, so a stale value can never pass for a fresh one.
    task automatic send_byte(input logic [7:0] b, input int gap);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data  <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~b;
        repeat (gap) @(posedge clk);
    endtask
endmodule // msg_host_model

`default_nettype wire

/* tb/tb_monitor_security_gate.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Self-checking bench of the monitor security gate.
module tb_monitor_security_gate
    import msg_pkg::*;
;
    logic clk, rst_b, warm_reset, rx_valid, tx_break, sp_reply_valid;
    logic ram_wr_en, ram_rd_en, instr_valid, resume_valid, nvm_rd_en, gated_rd_valid;
    logic fetch_en, illegal_addr_reset, key_wr_en, mass_erase, unlocked;
    logic [7:0] rx_data, cpu_a, cpu_x, cpu_h, cpu_ccr, ram_wr_data, ram_rd_data, resume_a;
    logic [7:0] resume_x, resume_h, resume_ccr, nvm_rd_data, gated_rd_data, key_wr_data;
    logic [15:0] sp_reply, cpu_pc, cpu_sp, ram_addr, resume_pc, resume_sp, sp_seen;
    logic [2:0] key_wr_idx;
    msg_instr_e instr_code;
    msg_instr_e marks [$];
    logic [7:0] ram [65536];
    logic [7:0] key_load [8];
    logic [7:0] key_sent [8];
    int n_errors, tests_run, n_break, n_illegal, n_resume;

    msg_gate dut (.clk(clk), .rst_b(rst_b), .warm_reset(warm_reset), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_break(tx_break), .sp_reply_valid(sp_reply_valid),
        .sp_reply(sp_reply), .cpu_pc(cpu_pc), .cpu_sp(cpu_sp), .cpu_a(cpu_a), .cpu_x(cpu_x),
        .cpu_h(cpu_h), .cpu_ccr(cpu_ccr), .ram_wr_en(ram_wr_en), .ram_rd_en(ram_rd_en),
        .ram_addr(ram_addr), .ram_wr_data(ram_wr_data), .ram_rd_data(ram_rd_data),
        .instr_valid(instr_valid), .instr_code(instr_code), .resume_valid(resume_valid),
        .resume_pc(resume_pc), .resume_sp(resume_sp), .resume_a(resume_a),
        .resume_x(resume_x), .resume_h(resume_h), .resume_ccr(resume_ccr),
        .nvm_rd_en(nvm_rd_en), .nvm_rd_data(nvm_rd_data), .gated_rd_valid(gated_rd_valid),
        .gated_rd_data(gated_rd_data), .fetch_en(fetch_en),
        .illegal_addr_reset(illegal_addr_reset), .key_wr_en(key_wr_en),
        .key_wr_idx(key_wr_idx), .key_wr_data(key_wr_data), .mass_erase(mass_erase),
        .unlocked(unlocked));

    msg_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data));

    // ==========================================================================
    // Clock, internal RAM model and output monitors.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // RAM answers one cycle after the strobe; otherwise the data keeps toggling.
    always @(posedge clk) begin
        if (ram_wr_en === 1'b1 && rst_b === 1'b1) ram[ram_addr] <= ram_wr_data;
        ram_rd_data <= (ram_rd_en === 1'b1) ? ram[ram_addr] : ~ram_rd_data;
    end

    // Pulses are counted or captured in the cycle that they stand.
    always @(posedge clk) begin
        if (tx_break === 1'b1) n_break <= n_break + 1;
        if (illegal_addr_reset === 1'b1) n_illegal <= n_illegal + 1;
        if (resume_valid === 1'b1) n_resume <= n_resume + 1;
        if (instr_valid === 1'b1 && rst_b === 1'b1) marks.push_back(instr_code);
        if (sp_reply_valid === 1'b1) sp_seen <= sp_reply;
    end

    // ==========================================================================
    // Comparison and closing tasks.
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_marks(input msg_instr_e a, input msg_instr_e b);
        chk_val("mark count", 16'h0002, 16'(marks.size()));
        if (marks.size() >= 2) begin
            chk_val("first mark", {14'h0000, a}, {14'h0000, marks[0]});
            chk_val("second mark", {14'h0000, b}, {14'h0000, marks[1]});
        end
        marks.delete();
    endtask

    // Final stack pointer of the entry frame for a given entry pointer.
    function automatic logic [15:0] frame_base(input logic [15:0] sp);
        return sp - 16'h0006;
    endfunction

    task automatic print_verdict;
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================================
    // Scenario tasks.
    // Power-on reset with fresh processor state, key load and optional erase on the last write.
    task automatic power_on(input bit erase);
        logic [15:0] f;
        @(posedge clk);
        rst_b <= 1'b0;
        cpu_pc <= 16'($urandom);
        cpu_sp <= 16'h0100 + 16'($urandom_range(8, 255));
        {cpu_a, cpu_x, cpu_h, cpu_ccr} <= $urandom;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            key_wr_en   <= 1'b1;
            key_wr_idx  <= 3'(i);
            key_wr_data <= key_load[i];
            mass_erase  <= erase && i == 7;
        end
        @(posedge clk);
        key_wr_en  <= 1'b0;
        mass_erase <= 1'b0;
        f = frame_base(cpu_sp);
        chk_val("lock after power-on", 16'h0000, {15'h0000, unlocked});
        chk_val("frame pc high", {8'h00, cpu_pc[15:8]}, {8'h00, ram[f + 16'h0005]});
        chk_val("frame pc low", {8'h00, cpu_pc[7:0]}, {8'h00, ram[f + 16'h0006]});
        chk_val("frame index high", {8'h00, cpu_h}, {8'h00, ram[f + 16'h0001]});
        chk_marks(MSG_INSTR_SOFT_INT, MSG_INSTR_PUSH_HI);
    endtask

    // Eight key bytes; no break may appear before the eighth.
    task automatic attempt(input bit good);
        int nb;
        nb = n_break;
        for (int i = 0; i < 7; i++) host.send_byte(key_sent[i], $urandom_range(0, 3));
        repeat (4) @(posedge clk);
        chk_val("break before eighth", 16'(nb), 16'(n_break));
        host.send_byte(key_sent[7], 0);
        repeat (6) @(posedge clk);
        chk_val("break after eighth", 16'(nb + 1), 16'(n_break));
        chk_val("lock flag", {15'h0000, good}, {15'h0000, unlocked});
        chk_val("status byte", good ? 16'h0040 : 16'h0000, {8'h00, ram[16'h0080]});
    endtask

    // One memory read and one fetch, back to back.
    task automatic nvm_probe(input bit good);
        logic [7:0] d;
        int ni;
        d  = 8'($urandom_range(1, 255));
        ni = n_illegal;
        @(posedge clk);
        nvm_rd_en   <= 1'b1;
        nvm_rd_data <= d;
        @(posedge clk);
        nvm_rd_en   <= 1'b0;
        nvm_rd_data <= ~d;
        fetch_en    <= 1'b1;
        #1;
        chk_val("gated read valid", 16'h0001, {15'h0000, gated_rd_valid});
        chk_val("gated read", good ? {8'h00, d} : 16'h0000, {8'h00, gated_rd_data});
        @(posedge clk);
        fetch_en <= 1'b0;
        @(posedge clk);
        #1;
        chk_val("illegal resets", good ? 16'(ni) : 16'(ni + 1), 16'(n_illegal));
    endtask

    task automatic read_sp;
        sp_seen = 16'hxxxx;
        host.send_byte(8'h0C, 2);
        chk_val("stack pointer reply", frame_base(cpu_sp) + 16'h0001, sp_seen);
    endtask

    // ==========================================================================
    // Main sequence.
    initial begin
        logic [15:0] f, new_pc;
        logic [7:0] new_a;
        {rst_b, warm_reset, nvm_rd_en, fetch_en, key_wr_en, mass_erase} = '0;
        {cpu_pc, cpu_sp, cpu_a, cpu_x, cpu_h, cpu_ccr} = '0;
        {nvm_rd_data, key_wr_data, key_wr_idx, ram_rd_data, sp_seen} = '0;
        {n_errors, tests_run, n_break, n_illegal, n_resume} = '0;
        void'($urandom(72));
        for (int i = 0; i < 8; i++) key_load[i] = 8'($urandom);
        key_sent = key_load;
        power_on(1'b0);
        attempt(1'b1);
        nvm_probe(1'b1);
        read_sp();
        f      = frame_base(cpu_sp);
        new_pc = 16'($urandom);
        new_a  = 8'($urandom);
        {ram[f + 16'h0005], ram[f + 16'h0006], ram[f + 16'h0003]} = {new_pc, new_a};
        host.send_byte(8'h28, 12);
        chk_val("resume pulses", 16'h0001, 16'(n_resume));
        chk_marks(MSG_INSTR_PULL_HI, MSG_INSTR_RET_INT);
        chk_val("resume pc", new_pc, resume_pc);
        chk_val("resume sp", f + 16'h0006, resume_sp);
        chk_val("resume a", {8'h00, new_a}, {8'h00, resume_a});
        chk_val("resume index high", {8'h00, cpu_h}, {8'h00, resume_h});
        n_break = 0;
        @(posedge clk);
        warm_reset <= 1'b1;
        @(posedge clk);
        warm_reset <= 1'b0;
        repeat (14) @(posedge clk);
        chk_val("break after warm reset", 16'h0001, 16'(n_break));
        chk_val("lock after warm reset", 16'h0001, {15'h0000, unlocked});
        chk_marks(MSG_INSTR_SOFT_INT, MSG_INSTR_PUSH_HI);
        nvm_probe(1'b1);
        power_on(1'b0);
        key_sent[$urandom_range(0, 7)] ^= 8'h01 << $urandom_range(0, 7);
        attempt(1'b0);
        nvm_probe(1'b0);
        for (int i = 0; i < 8; i++) key_sent[i] = 8'hFF;
        power_on(1'b1);
        attempt(1'b1);
        print_verdict();
    end

    // Watchdog well beyond the few hundred cycles that the run needs.
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
endmodule // tb_monitor_security_gate

`default_nettype wire
